/* File: core/fpsb_device.sv */
/*
 float led pulse sequencer with ambient light monitor (device end).
 assumes pulse_strobe marks each pulse start, adc_valid follows with the
 result of that pulse, and the host holds register requests until ack.
*/
// Implementation choices: the APB interface to the registers and the register addresses.
// Notes on behaviour
// - led fires only where pattern bit set
// - each position adds or subtracts per math
// - four-position sequence repeats every four pulses
// - one accumulated value per sample period
// - integration start gets fixed 9 us added
// - math 2 and 1 add two three
// - software centres negative phase on dump
// - subtract cycles compared against ambient threshold
// - compared result is raw minus channel offset
// - each channel counts its own exceedances
// - count above limit sets channel alarm flag
// - output pin driven from selectable flag combination
// - host enables state machine clock first
// - mode value one enters program mode
// - program mode takes config in any order
// - mode value two starts normal sampling
`timescale 1ns/100ps
`include "fpsb_defines.svh"
module fpsb_device
   import fpsb_pkg::*;
#(
   parameter int CH = 4,
   parameter int ACC_W = 27
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // register port
   fpsb_if.dev bus,
   // pulse timing and converter
   input wire logic pulse_strobe,
   input wire logic adc_valid,
   input wire logic [CH-1:0][13:0] adc_raw,
   // sequencer outputs
   output logic led_fire,
   output logic integ_start,
   output logic [ACC_W-1:0] data_out,
   output logic data_valid,
   output logic general_output_pin
);
   typedef struct packed {
      fpsb_mode_t mode;
      logic clk_en;
      logic [15:0] flt_cfg;
      logic [15:0] fire_cfg;
      logic [15:0] thresh;
      logic [7:0] limit;
      logic [1:0] gp_sel;
      logic [7:0] npulse;
      logic [15:0] idelay;
      logic [CH-1:0][15:0] ofs;
      logic [1:0] pos;
      logic cur_add;
      logic [7:0] pulses;
      logic [ACC_W-1:0] acc;
      logic [ACC_W-1:0] data;
      logic dvalid;
      logic led;
      logic istart;
      logic [16:0] dly;
      logic dly_run;
      logic [15:0] rdata;
      logic ack;
      logic gpio;
      logic clear_mon;
   } dev_st_t;

   dev_st_t s_r;
   dev_st_t s_nxt;
   logic [CH-1:0] flags;
   logic running;
   logic signed [ACC_W-1:0] sum;
   logic [1:0] ofs_idx;

   // ****************************************
   // add or subtract for a pulse position
   // ****************************************
   function automatic logic pos_add(input logic [1:0] pos, input logic [15:0] cfg);
      logic [1:0] m12;
      logic [1:0] m34;
      m12 = cfg[`FPSB_M12_LSB +: 2];
      m34 = cfg[`FPSB_M34_LSB +: 2];
      case (pos)
         2'h0: pos_add = m12[0];
         2'h1: pos_add = m12[1];
         2'h2: pos_add = m34[0];
         default: pos_add = m34[1];
      endcase
   endfunction : pos_add

   // ****************************************
   // ambient monitor channels
   // ****************************************
   generate
      for (genvar i = 0; i < CH; i++) begin : g_chan
         fpsb_amb_chan u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .clear(s_r.clear_mon),
            .sample_en(running && adc_valid && !s_r.cur_add),
            .adc_raw(adc_raw[i]),
            .adc_ofs(s_r.ofs[i]),
            .thresh(s_r.thresh),
            .limit(s_r.limit),
            .flag(flags[i])
         );
      end
   endgenerate

   assign running = (s_r.mode == MODE_RUN) && s_r.clk_en;
   assign ofs_idx = bus.reg_addr[1:0];

   always_comb begin
      sum = '0;
      for (int i = 0; i < CH; i++) begin
         sum = sum + ACC_W'(fpsb_corr(adc_raw[i], s_r.ofs[i]));
      end
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      s_nxt = s_r;
      s_nxt.ack = 1'b0;
      s_nxt.dvalid = 1'b0;
      s_nxt.istart = 1'b0;
      s_nxt.clear_mon = 1'b0;
      // register port
      if ((bus.reg_wr || bus.reg_rd) && !s_r.ack) begin
         s_nxt.ack = 1'b1;
         case (bus.reg_addr)
            `FPSB_A_MODE: s_nxt.rdata = {14'h0000, s_r.mode};
            `FPSB_A_CLKCTL: s_nxt.rdata = {8'h00, s_r.clk_en, 7'h00};
            `FPSB_A_FLTCFG: s_nxt.rdata = s_r.flt_cfg;
            `FPSB_A_FIRE: s_nxt.rdata = s_r.fire_cfg;
            `FPSB_A_THRESH: s_nxt.rdata = s_r.thresh;
            `FPSB_A_LIMIT: s_nxt.rdata = {8'h00, s_r.limit};
            `FPSB_A_FLAGS: s_nxt.rdata = 16'(flags);
            `FPSB_A_GPSEL: s_nxt.rdata = {14'h0000, s_r.gp_sel};
            `FPSB_A_NPULSE: s_nxt.rdata = {8'h00, s_r.npulse};
            `FPSB_A_IDELAY: s_nxt.rdata = s_r.idelay;
            default: begin
               if (bus.reg_addr >= `FPSB_A_OFS0 && bus.reg_addr <= `FPSB_A_OFS3) begin
                  s_nxt.rdata = s_r.ofs[ofs_idx];
               end else begin
                  s_nxt.rdata = 16'h0000;
               end
            end
         endcase
         if (bus.reg_wr) begin
            if (bus.reg_addr == `FPSB_A_MODE) begin
               if (bus.reg_wdata == `FPSB_MODE_PROG) begin
                  s_nxt.mode = MODE_PROG;
                  s_nxt.clear_mon = 1'b1;
               end else if (bus.reg_wdata == `FPSB_MODE_RUN) begin
                  s_nxt.mode = MODE_RUN;
               end else begin
                  s_nxt.mode = MODE_STBY;
               end
               s_nxt.pos = 2'h0;
               s_nxt.pulses = 8'h00;
               s_nxt.acc = '0;
               s_nxt.dly_run = 1'b0;
            end else if (bus.reg_addr == `FPSB_A_CLKCTL) begin
               s_nxt.clk_en = bus.reg_wdata[`FPSB_CLKEN_BIT];
            end else if (s_r.mode == MODE_PROG) begin
               case (bus.reg_addr)
                  `FPSB_A_FLTCFG: s_nxt.flt_cfg = bus.reg_wdata;
                  `FPSB_A_FIRE: s_nxt.fire_cfg = bus.reg_wdata;
                  `FPSB_A_THRESH: s_nxt.thresh = bus.reg_wdata;
                  `FPSB_A_LIMIT: s_nxt.limit = bus.reg_wdata[7:0];
                  `FPSB_A_GPSEL: s_nxt.gp_sel = bus.reg_wdata[1:0];
                  `FPSB_A_NPULSE: s_nxt.npulse = bus.reg_wdata[7:0];
                  `FPSB_A_IDELAY: s_nxt.idelay = bus.reg_wdata;
                  default: begin
                     if (bus.reg_addr >= `FPSB_A_OFS0 && bus.reg_addr <= `FPSB_A_OFS3) begin
                        s_nxt.ofs[ofs_idx] = bus.reg_wdata;
                     end
                  end
               endcase
            end
         end
      end
      // pulse sequencing
      if (running && pulse_strobe) begin
         s_nxt.led = s_r.fire_cfg[`FPSB_FIRE_LSB + 32'(s_r.pos)];
         s_nxt.cur_add = pos_add(s_r.pos, s_r.flt_cfg);
         s_nxt.pos = s_r.pos + 2'h1;
         s_nxt.dly = 17'(s_r.idelay) + 17'(`FPSB_IFIX_CYC);
         s_nxt.dly_run = 1'b1;
      end else if (s_r.dly_run) begin
         if (s_r.dly == 17'h00000) begin
            s_nxt.istart = 1'b1;
            s_nxt.dly_run = 1'b0;
         end else begin
            s_nxt.dly = s_r.dly - 17'h00001;
         end
      end
      // accumulation
      if (running && adc_valid) begin
         s_nxt.led = 1'b0;
         if (s_r.cur_add) begin
            s_nxt.acc = s_r.acc + sum;
         end else begin
            s_nxt.acc = s_r.acc - sum;
         end
         if (s_r.pulses + 8'h01 >= s_r.npulse) begin
            s_nxt.data = s_nxt.acc;
            s_nxt.dvalid = 1'b1;
            s_nxt.acc = '0;
            s_nxt.pulses = 8'h00;
            s_nxt.pos = 2'h0;
         end else begin
            s_nxt.pulses = s_r.pulses + 8'h01;
         end
      end
      // output pin combination
      case (s_r.gp_sel)
         2'h1: s_nxt.gpio = |flags;
         2'h2: s_nxt.gpio = &flags;
         2'h3: s_nxt.gpio = (|flags) || s_nxt.dvalid;
         default: s_nxt.gpio = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.npulse <= `FPSB_NPULSE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign bus.reg_rdata = s_r.rdata;
   assign bus.reg_ack = s_r.ack;
   assign bus.amb_alarm = s_r.gpio;
   assign led_fire = s_r.led;
   assign integ_start = s_r.istart;
   assign data_out = s_r.data;
   assign data_valid = s_r.dvalid;
   assign general_output_pin = s_r.gpio;
endmodule : fpsb_device

/* File: core/fpsb_defines.svh */
/*
 constants of the float pulse sequencer: register offsets, field positions,
 mode codes, timing counts and host-side register map.
 assumes inclusion by bare name wherever a constant is needed.
*/
`ifndef FPSB_DEFINES_SVH
`define FPSB_DEFINES_SVH

// ****************************************
// device register offsets
// ****************************************
`define FPSB_A_MODE 8'h10
`define FPSB_A_CLKCTL 8'h4B
`define FPSB_A_FLTCFG 8'h58
`define FPSB_A_FIRE 8'h5A
`define FPSB_A_OFS0 8'h18
`define FPSB_A_OFS3 8'h1B
`define FPSB_A_THRESH 8'h40
`define FPSB_A_LIMIT 8'h41
`define FPSB_A_FLAGS 8'h42
`define FPSB_A_GPSEL 8'h43
`define FPSB_A_NPULSE 8'h44
`define FPSB_A_IDELAY 8'h45

// ****************************************
// fields and values
// ****************************************
`define FPSB_MODE_PROG 16'h0001
`define FPSB_MODE_RUN 16'h0002
`define FPSB_CLKEN_BIT 7
`define FPSB_CLKEN_VAL 16'h0080
`define FPSB_FIRE_LSB 8
`define FPSB_M12_LSB 5
`define FPSB_M34_LSB 10
`define FPSB_NPULSE_RST 8'h04

// ****************************************
// timing
// ****************************************
`define FPSB_CLK_NS 8
`define FPSB_IFIX_NS 9000
`define FPSB_IFIX_CYC ((`FPSB_IFIX_NS + `FPSB_CLK_NS - 1) / `FPSB_CLK_NS)

// ****************************************
// host apb map
// ****************************************
`define FPSB_H_CMD 12'h000
`define FPSB_H_CTRL 12'h004
`define FPSB_H_STAT 12'h008
`define FPSB_H_ISTAT 12'h00C
`define FPSB_H_IMASK 12'h010
`define FPSB_CMD_RD 31
`define FPSB_CTRL_BOOT 0
`define FPSB_CTRL_RUN 1

`endif

/* File: core/fpsb_pkg.sv */
/*
 types of the float pulse sequencer: modes, host states, channel state struct,
 offset correction function.
 assumes fpsb_defines.svh on the include path.
*/
package fpsb_pkg;
   `include "fpsb_defines.svh"

   // ****************************************
   // enumerations
   // ****************************************
   typedef enum logic [1:0] {
      MODE_STBY = 2'b00,
      MODE_PROG = 2'b01,
      MODE_RUN = 2'b10
   } fpsb_mode_t;

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_CLK = 3'b001,
      H_PROG = 3'b010,
      H_RUN = 3'b011,
      H_CMD = 3'b100,
      H_WAIT = 3'b101
   } fpsb_hst_t;

   // ****************************************
   // channel monitor state
   // ****************************************
   typedef struct packed {
      logic [7:0] cnt;
      logic flag;
   } fpsb_chan_t;

   // ****************************************
   // offset-corrected adc result
   // ****************************************
   function automatic logic signed [16:0] fpsb_corr(input logic [13:0] raw,
                                                    input logic [15:0] ofs);
      fpsb_corr = $signed({3'h0, raw}) - $signed({1'h0, ofs});
   endfunction : fpsb_corr
endpackage : fpsb_pkg

/* File: core/fpsb_if.sv */
/*
 register port between host controller and sequencer device.
 assumes one clock shared by both ends; request held until ack.
*/
`timescale 1ns/100ps
interface fpsb_if;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic reg_ack;
   logic amb_alarm;

   modport dev (input reg_wr, reg_rd, reg_addr, reg_wdata,
                output reg_rdata, reg_ack, amb_alarm);
   modport host (output reg_wr, reg_rd, reg_addr, reg_wdata,
                 input reg_rdata, reg_ack, amb_alarm);
endinterface : fpsb_if

/* File: core/fpsb_amb_chan.sv */
/*
 one channel of the ambient light monitor: exceedance counter and flag.
 assumes sample_en only on subtract cycles while sampling.
*/
`timescale 1ns/100ps
module fpsb_amb_chan
   import fpsb_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic clear,
   input wire logic sample_en,
   // data and settings
   input wire logic [13:0] adc_raw,
   input wire logic [15:0] adc_ofs,
   input wire logic [15:0] thresh,
   input wire logic [7:0] limit,
   // result
   output logic flag
);
   fpsb_chan_t s_r;
   fpsb_chan_t s_nxt;
   logic signed [16:0] res;

   // ****************************************
   // counting
   // ****************************************
   always_comb begin
      s_nxt = s_r;
      res = fpsb_corr(adc_raw, adc_ofs);
      if (clear) begin
         s_nxt = '0;
      end else if (sample_en && (res > $signed({1'b0, thresh}))) begin
         if (s_r.cnt != 8'hFF) begin
            s_nxt.cnt = s_r.cnt + 8'h01;
         end
      end
      if (!clear && (s_nxt.cnt > limit)) begin
         s_nxt.flag = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign flag = s_r.flag;
endmodule : fpsb_amb_chan

/* File: core/fpsb_host.sv */
/*
 host controller end: apb slave that turns software orders into register
 transfers on the device port, with the start-up order built in.
 assumes an apb master on the software side.
*/
`timescale 1ns/100ps
`include "fpsb_defines.svh"
module fpsb_host
   import fpsb_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // interrupt
   output logic irq,
   // device port
   fpsb_if.host dev
);
   typedef struct packed {
      fpsb_hst_t st;
      fpsb_hst_t after;
      logic [31:0] cmd;
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic [1:0] istat;
      logic [1:0] imask;
      logic alarm_q;
      logic pready;
      logic [31:0] prdata;
      logic irq;
   } hst_st_t;

   hst_st_t s_r;
   hst_st_t s_nxt;
   logic access;
   logic idle;

   assign access = psel && penable;
   assign idle = (s_r.st == H_IDLE);

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      s_nxt = s_r;
      // apb: one wait cycle, data taken on completion edge
      if (access && !s_r.pready) begin
         s_nxt.pready = 1'b1;
         case (paddr)
            `FPSB_H_CMD: s_nxt.prdata = s_r.cmd;
            `FPSB_H_STAT: s_nxt.prdata = {s_r.rdata, 14'h0000, dev.amb_alarm, !idle};
            `FPSB_H_ISTAT: s_nxt.prdata = {30'h00000000, s_r.istat};
            `FPSB_H_IMASK: s_nxt.prdata = {30'h00000000, s_r.imask};
            default: s_nxt.prdata = 32'h00000000;
         endcase
      end else if (access && s_r.pready) begin
         s_nxt.pready = 1'b0;
         if (pwrite) begin
            case (paddr)
               `FPSB_H_CMD: begin
                  if (idle) begin
                     s_nxt.cmd = pwdata;
                     s_nxt.st = H_CMD;
                  end
               end
               `FPSB_H_CTRL: begin
                  if (idle && pwdata[`FPSB_CTRL_BOOT]) begin
                     s_nxt.st = H_CLK;
                  end else if (idle && pwdata[`FPSB_CTRL_RUN]) begin
                     s_nxt.st = H_RUN;
                  end
               end
               `FPSB_H_IMASK: s_nxt.imask = pwdata[1:0];
               default: begin
               end
            endcase
         end else if (paddr == `FPSB_H_ISTAT) begin
            s_nxt.istat = s_r.istat & ~s_r.prdata[1:0];
         end
      end else begin
         s_nxt.pready = 1'b0;
      end
      // device transfers
      case (s_r.st)
         H_CLK: begin
            s_nxt.wr = 1'b1;
            s_nxt.addr = `FPSB_A_CLKCTL;
            s_nxt.wdata = `FPSB_CLKEN_VAL;
            s_nxt.after = H_PROG;
            s_nxt.st = H_WAIT;
         end
         H_PROG: begin
            s_nxt.wr = 1'b1;
            s_nxt.addr = `FPSB_A_MODE;
            s_nxt.wdata = `FPSB_MODE_PROG;
            s_nxt.after = H_IDLE;
            s_nxt.st = H_WAIT;
         end
         H_RUN: begin
            s_nxt.wr = 1'b1;
            s_nxt.addr = `FPSB_A_MODE;
            s_nxt.wdata = `FPSB_MODE_RUN;
            s_nxt.after = H_IDLE;
            s_nxt.st = H_WAIT;
         end
         H_CMD: begin
            s_nxt.wr = !s_r.cmd[`FPSB_CMD_RD];
            s_nxt.rd = s_r.cmd[`FPSB_CMD_RD];
            s_nxt.addr = s_r.cmd[23:16];
            s_nxt.wdata = s_r.cmd[15:0];
            s_nxt.after = H_IDLE;
            s_nxt.st = H_WAIT;
         end
         H_WAIT: begin
            if (dev.reg_ack) begin
               s_nxt.wr = 1'b0;
               s_nxt.rd = 1'b0;
               if (s_r.rd) begin
                  s_nxt.rdata = dev.reg_rdata;
               end
               s_nxt.st = s_r.after;
               if (s_r.after == H_IDLE) begin
                  s_nxt.istat[0] = 1'b1;
               end
            end
         end
         default: begin
         end
      endcase
      // alarm rise event
      s_nxt.alarm_q = dev.amb_alarm;
      if (dev.amb_alarm && !s_r.alarm_q) begin
         s_nxt.istat[1] = 1'b1;
      end
      s_nxt.irq = |(s_nxt.istat & s_nxt.imask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = 1'b0;
   assign irq = s_r.irq;
   assign dev.reg_wr = s_r.wr;
   assign dev.reg_rd = s_r.rd;
   assign dev.reg_addr = s_r.addr;
   assign dev.reg_wdata = s_r.wdata;
endmodule : fpsb_host

/* File: verif/fpsb_chk.sv */
/*
 checker on the register port between host end and device end.
 assumes one clock and an async active-low reset on both ends.
*/
`timescale 1ns/100ps
module fpsb_chk (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic amb_alarm
);
   logic [1:0] md_r;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ****************
   // mode tracking
   // ****************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         md_r <= 2'h0;
      end else if (reg_ack && reg_wr && reg_addr == 8'h10) begin
         md_r <= reg_wdata[1:0];
      end
   end
   // ****************
   // properties
   // ****************
   a_ack_next: assert property ((reg_wr || reg_rd) && !reg_ack |=> reg_ack)
      else $error("no ack after request");
   a_ack_single: assert property (reg_ack |=> !reg_ack)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property ($rose(reg_ack) |-> $past(reg_wr || reg_rd))
      else $error("ack without request");
   a_req_hold: assert property ((reg_wr || reg_rd) && !reg_ack |=>
      $stable(reg_addr) && $stable(reg_wdata) && $stable(reg_wr))
      else $error("request changed before ack");
   a_req_drop: assert property (reg_ack |=> !reg_wr && !reg_rd)
      else $error("request not dropped after ack");
   a_rw_excl: assert property (!(reg_wr && reg_rd))
      else $error("read and write together");
   a_boot_order: assert property (
      reg_ack && reg_wr && reg_addr == 8'h4B && reg_wdata == 16'h0080 |->
      ##[1:8] (reg_wr && reg_addr == 8'h10 && reg_wdata == 16'h0001))
      else $error("program mode not entered after clock enable");
   a_alarm_clear: assert property (
      reg_ack && reg_wr && reg_addr == 8'h10 && reg_wdata == 16'h0001 |->
      ##[1:3] !amb_alarm)
      else $error("alarm not cleared on program mode");
   a_flags_prog: assert property (
      reg_rd && reg_ack && reg_addr == 8'h42 && md_r == 2'h1 |-> reg_rdata == 16'h0000)
      else $error("flags set in program mode");
   a_alarm_run: assert property ($rose(amb_alarm) |-> md_r == 2'h2)
      else $error("alarm rose outside sampling");
   a_unmapped_zero: assert property (reg_rd && reg_ack && reg_addr == 8'hEE |->
      reg_rdata == 16'h0000)
      else $error("unknown address read not zero");
endmodule : fpsb_chk

/* File: verif/fpsb_tb_top.sv */
/*
 testbench: host end and device end joined by the register port.
 assumes apb software side and pulse/adc stimulus from the bench.
*/
`timescale 1ns/100ps
`include "fpsb_defines.svh"
module fpsb_tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic pulse_strobe, adc_valid, led_fire, integ_start, data_valid, general_output_pin;
   logic [3:0][13:0] adc_raw;
   logic [26:0] data_out, acc;
   logic [15:0] dq;
   logic gp_exp;
   int err_count, samples_checked, np;
   logic [23:0] cfg [12] = '{24'h430001, 24'h410005, 24'h400100, 24'h180010, 24'h190010,
      24'h1A0010, 24'h1B0010, 24'h450003, 24'h440008, 24'h5A0600, 24'h580440, 24'h430001};
   fpsb_if fif ();
   fpsb_device #(.CH(4), .ACC_W(27)) fpsb_device_i (.pclk, .presetn, .bus(fif),
      .pulse_strobe, .adc_valid, .adc_raw, .led_fire, .integ_start, .data_out,
      .data_valid, .general_output_pin);
   fpsb_host fpsb_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .irq, .dev(fif));
   fpsb_chk fpsb_chk_i (.pclk, .presetn, .reg_wr(fif.reg_wr), .reg_rd(fif.reg_rd),
      .reg_addr(fif.reg_addr), .reg_wdata(fif.reg_wdata), .reg_rdata(fif.reg_rdata),
      .reg_ack(fif.reg_ack), .amb_alarm(fif.amb_alarm));
   // ****************
   // tasks
   // ****************
   task print_verdict;
      if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task idle;
      q = 32'h1;
      while (q[0] !== 1'b0) apb(1'b0, `FPSB_H_STAT, 32'h0);
   endtask : idle
   task dev(input logic r, input logic [7:0] a, input logic [15:0] d);
      apb(1'b1, `FPSB_H_CMD, {r, 7'h00, a, d});
      idle();
      dq = q[31:16];
   endtask : dev
   task pls(input int p, input logic [13:0] s0, input logic [13:0] s1, input logic meas);
      int n;
      logic add;
      add = (p == 1 || p == 2);
      pulse_strobe <= 1'b1;
      @(posedge pclk);
      pulse_strobe <= 1'b0;
      @(posedge pclk);
      n = 2;
      chk(led_fire, add);
      while (meas && integ_start !== 1'b1 && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      if (meas) chk(n, 3 + `FPSB_IFIX_CYC + 3);
      adc_valid <= 1'b1;
      adc_raw <= add ? {4{14'h3FFF}} : {14'h0020, 14'h0020, s1, s0};
      acc = add ? acc + 27'h000FFBC : acc - (27'(s0) + 27'(s1));
      np++;
      @(posedge pclk);
      adc_valid <= 1'b0;
      @(posedge pclk);
      chk(data_valid, np == 8);
      if (np == 8) begin
         chk(data_out, acc);
         chk(general_output_pin, gp_exp);
         np = 0;
         acc = 27'h0;
      end
   endtask : pls
   task samp(input logic [13:0] s0, input logic [13:0] s1, input logic meas);
      for (int i = 0; i < 8; i++) pls(i % 4, s0, s1, meas && i == 0);
   endtask : samp
   // ****************
   // clock, watchdog, tests
   // ****************
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      repeat (60000) @(posedge pclk);
      err_count++;
      print_verdict();
   end
   initial begin
      {presetn, psel, penable, pwrite, pulse_strobe, adc_valid, gp_exp} = 7'h00;
      {paddr, pwdata, adc_raw, acc, np, err_count, samples_checked} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `FPSB_H_IMASK, 32'h0);
      chk(q, 32'h0);
      apb(1'b1, `FPSB_H_CTRL, 32'h1);
      idle();
      apb(1'b0, `FPSB_H_ISTAT, 32'h0);
      chk(q[0], 1'b1);
      chk(irq, 1'b0);
      apb(1'b0, `FPSB_H_ISTAT, 32'h0);
      chk(q[0], 1'b0);
      for (int i = 0; i < 12; i++) dev(1'b0, cfg[i][23:16], cfg[i][15:0]);
      apb(1'b1, `FPSB_H_IMASK, 32'h2);
      apb(1'b1, `FPSB_H_CTRL, 32'h2);
      idle();
      samp(14'h0110, 14'h0050, 1'b1);
      dev(1'b1, 8'h42, 16'h0);
      chk(dq, 16'h0);
      samp(14'h0111, 14'h0050, 1'b0);
      samp(14'h0050, 14'h0111, 1'b0);
      dev(1'b1, 8'h42, 16'h0);
      chk(dq, 16'h0);
      gp_exp = 1'b1;
      samp(14'h0111, 14'h0050, 1'b0);
      dev(1'b1, 8'h42, 16'h0);
      chk(dq, 16'h1);
      chk(general_output_pin, 1'b1);
      chk(irq, 1'b1);
      apb(1'b0, `FPSB_H_ISTAT, 32'h0);
      chk(q[1], 1'b1);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      apb(1'b1, `FPSB_H_CTRL, 32'h1);
      idle();
      dev(1'b1, 8'h42, 16'h0);
      chk(dq, 16'h0);
      chk(general_output_pin, 1'b0);
      apb(1'b0, 12'h0FC, 32'h0);
      chk(q, 32'h0);
      dev(1'b1, 8'hEE, 16'h0);
      chk(dq, 16'h0);
      dev(1'b0, 8'h43, 16'h3);
      apb(1'b1, `FPSB_H_CTRL, 32'h2);
      idle();
      samp(14'h0050, 14'h0050, 1'b0);
      chk(pslverr, 1'b0);
      print_verdict();
   end
endmodule : fpsb_tb_top
